/* File: src/iwf_setup_io.sv */
// What this block does
// - Bits 5:4 pick debounce: none,5,20,50 ms
// - No filter: count clean edges up to 20kHz
// - Filter hides contact bounce from the counter
// - One word is eight bits, two hex
// - Word count 1..8 binary in low bits
// - Wrong digit count gives syntax error
// - Reads return exactly configured words as hex
// - Last hex digit maps to lowest lines
// - Output bits above physical lines discarded
// - Input bits above physical lines read one
// - Single-bit commands ignore word count
// - Byte four is last two setup characters
// - Setup read returns setup currently held
// - Shipped: address 1, 300 baud, model words
`timescale 1ns/1ps
`include "iwf_consts.svh"

module iwf_setup_io #(
  parameter int          IO_LINES   = 15,
  parameter logic [7:0]  BYTE4_DEF  = `IWF_WORDS_DEF,
  parameter logic [63:0] INIT_OUT   = 64'h0000_0000_0000_0000,
  parameter int          F5_CYCLES  = `IWF_FILT5_US * `IWF_CLK_MHZ,
  parameter int          F20_CYCLES = `IWF_FILT20_US * `IWF_CLK_MHZ,
  parameter int          F50_CYCLES = `IWF_FILT50_US * `IWF_CLK_MHZ
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic                setup_wr_stb,
  input  wire logic [31:0]         setup_wr_data,
  input  wire logic                write_armed,
  output logic                     setup_wr_ack,
  output logic                     setup_wr_refused,
  input  wire logic                setup_rd_stb,
  output logic [31:0]              setup_rd_data,
  output logic                     setup_rd_valid,
  input  wire logic                do_char_valid,
  input  wire logic [7:0]          do_char,
  input  wire logic                do_char_last,
  output logic                     do_ack,
  output logic                     syntax_err,
  output logic [IO_LINES-1:0]      out_lines,
  input  wire logic [IO_LINES-1:0] in_lines,
  input  wire logic                rd_stb,
  input  wire iwf_pkg::iwf_src_t   rd_src,
  output logic                     tx_valid,
  output logic [7:0]               tx_char,
  output logic                     tx_last,
  input  wire logic                tx_ready,
  output logic                     tx_busy,
  input  wire logic                bit_stb,
  input  wire logic [5:0]          bit_idx,
  input  wire logic                bit_val,
  output logic                     bit_err,
  input  wire logic                event_in,
  input  wire logic                event_clear,
  output logic [15:0]              event_count,
  output logic [3:0]               word_count,
  output iwf_pkg::iwf_filt_t       filter_sel
);
  import iwf_pkg::*;

  iwf_top_st_t st_reg;
  iwf_top_st_t st_next;
  logic [7:0]  byte4;
  logic [3:0]  words;
  iwf_filt_t   filt;
  logic [63:0] rd_word;
  logic [63:0] line_mask;
  logic        rd_start;
  logic        tx_busy_w;
  logic [3:0]  nib;

  // Fields of the fourth setup byte; bits 7:6 feed nothing
  assign byte4 = st_reg.setup[7:0];
  assign words = iwf_eff_words(byte4[`IWF_WORDS_MSB:`IWF_WORDS_LSB]);
  assign filt  = iwf_filt_t'(byte4[`IWF_FILT_MSB:`IWF_FILT_LSB]);
  assign nib   = iwf_hex_to_nib(do_char);

  // Lines that really exist; a width of 64 keeps every bit
  assign line_mask = (IO_LINES >= 64) ? {64{1'b1}} :
                     ((64'h1 << IO_LINES) - 64'h1);

  // Read source; missing lines read as ones so hosts see a fixed pattern
  always_comb
  begin
    case (rd_src)
      IWF_SRC_OUTPUT: rd_word = st_reg.outs;
      IWF_SRC_INIT:   rd_word = INIT_OUT;
      default:        rd_word = 64'(in_lines);
    endcase
    rd_word = (rd_word & line_mask) | ~line_mask;
  end

  // A read that lands while a reply is still going out is dropped
  assign rd_start = rd_stb & ~tx_busy_w;

  always_comb
  begin
    st_next = st_reg;
    st_next.syn_err  = 1'b0;
    st_next.do_ack   = 1'b0;
    st_next.wr_ack   = 1'b0;
    st_next.wr_ref   = 1'b0;
    st_next.rd_valid = 1'b0;
    st_next.bit_err  = 1'b0;

    // Setup write takes effect at once, but only after write enable
    if (setup_wr_stb)
    begin
      if (write_armed)
      begin
        st_next.setup  = setup_wr_data;
        st_next.wr_ack = 1'b1;
      end
      else
        st_next.wr_ref = 1'b1;
    end

    // Setup read shows the stored string, unused bits as written
    if (setup_rd_stb)
    begin
      st_next.rd_data  = st_reg.setup;
      st_next.rd_valid = 1'b1;
    end

    // Single-line writes use the index only, never the word count
    if (bit_stb)
    begin
      if (32'(bit_idx) < IO_LINES)
        st_next.outs[bit_idx] = bit_val;
      else
        st_next.bit_err = 1'b1;
    end

    // Parallel output digits shift in, so the last one lands lowest
    if (do_char_valid)
    begin
      if (!iwf_is_hex(do_char))
        st_next.bad = 1'b1;
      st_next.acc = {st_reg.acc[59:0], nib};
      if (st_reg.ndig != `IWF_DIG_SAT)
        st_next.ndig = st_reg.ndig + 5'h01;
      if (do_char_last)
      begin
        if (st_next.bad || st_next.ndig != {words, 1'b0})
          st_next.syn_err = 1'b1;
        else
        begin
          st_next.outs   = st_next.acc & line_mask;
          st_next.do_ack = 1'b1;
        end
        st_next.acc  = 64'h0000_0000_0000_0000;
        st_next.ndig = 5'h00;
        st_next.bad  = 1'b0;
      end
    end
  end

  // Shipped setup: upper bytes fixed, byte four from the model default
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_reg       <= '0;
      st_reg.setup <= {`IWF_SETUP_RST_HI, BYTE4_DEF};
      st_reg.outs  <= INIT_OUT;
    end
    else if (ce)
      st_reg <= st_next;
  end

  // Reply digits for the parallel reads
  iwf_hex_tx u_tx (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .start    (rd_start),
    .data     (rd_word),
    .words    (words),
    .tx_ready (tx_ready),
    .tx_valid (tx_valid),
    .tx_char  (tx_char),
    .tx_last  (tx_last),
    .busy     (tx_busy_w)
  );

  // Event counter behind the selectable debounce
  iwf_evt_filter #(
    .F5_CYCLES  (F5_CYCLES),
    .F20_CYCLES (F20_CYCLES),
    .F50_CYCLES (F50_CYCLES)
  ) u_flt (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .filt        (filt),
    .event_in    (event_in),
    .count_clear (event_clear),
    .count       (event_count)
  );

  assign tx_busy          = tx_busy_w;
  assign setup_wr_ack     = st_reg.wr_ack;
  assign setup_wr_refused = st_reg.wr_ref;
  assign setup_rd_data    = st_reg.rd_data;
  assign setup_rd_valid   = st_reg.rd_valid;
  assign do_ack           = st_reg.do_ack;
  assign syntax_err       = st_reg.syn_err;
  assign out_lines        = st_reg.outs[IO_LINES-1:0];
  assign bit_err          = st_reg.bit_err;
  assign word_count       = st_reg.setup[`IWF_WORDS_MSB:`IWF_WORDS_LSB];
  assign filter_sel       =
    iwf_filt_t'(st_reg.setup[`IWF_FILT_MSB:`IWF_FILT_LSB]);

endmodule : iwf_setup_io

/* File: include/iwf_consts.svh */
`ifndef IWF_CONSTS_SVH
`define IWF_CONSTS_SVH

// Upper three setup bytes as shipped: address 1, 300 baud, no parity
`define IWF_SETUP_RST_HI   24'h310701
// Default word count of the fourth setup byte
`define IWF_WORDS_DEF      8'h02
// Field positions inside the fourth setup byte
`define IWF_WORDS_LSB      0
`define IWF_WORDS_MSB      3
`define IWF_FILT_LSB       4
`define IWF_FILT_MSB       5
// Largest word count and hex digit limits
`define IWF_MAX_WORDS      4'h8
`define IWF_DIG_SAT        5'h11
// Clock rate and debounce constants
`define IWF_CLK_MHZ        200
`define IWF_FILT5_US       5000
`define IWF_FILT20_US      20000
`define IWF_FILT50_US      50000

`endif

/* File: include/iwf_pkg.sv */
package iwf_pkg;

  typedef enum logic [1:0] {
    IWF_FILT_NONE = 2'b00,
    IWF_FILT_5MS  = 2'b01,
    IWF_FILT_20MS = 2'b10,
    IWF_FILT_50MS = 2'b11
  } iwf_filt_t;

  typedef enum logic [1:0] {
    IWF_SRC_INPUT  = 2'b00,
    IWF_SRC_OUTPUT = 2'b01,
    IWF_SRC_INIT   = 2'b10
  } iwf_src_t;

  typedef enum logic [0:0] {
    IWF_TX_IDLE = 1'b0,
    IWF_TX_SEND = 1'b1
  } iwf_tx_st_t;

  typedef struct packed {
    logic        stable;
    logic [23:0] cnt;
    logic [15:0] count;
  } iwf_flt_st_t;

  typedef struct packed {
    iwf_tx_st_t  st;
    logic [63:0] sh;
    logic [4:0]  left;
    logic        valid;
    logic [7:0]  chr;
    logic        last;
  } iwf_tx_state_t;

  typedef struct packed {
    logic [31:0] setup;
    logic [63:0] acc;
    logic [4:0]  ndig;
    logic        bad;
    logic [63:0] outs;
    logic        syn_err;
    logic        do_ack;
    logic        wr_ack;
    logic        wr_ref;
    logic [31:0] rd_data;
    logic        rd_valid;
    logic        bit_err;
  } iwf_top_st_t;

  // ASCII hex digit test, both cases accepted
  function automatic logic iwf_is_hex(input logic [7:0] c);
    iwf_is_hex = (c >= 8'h30 && c <= 8'h39) ||
                 (c >= 8'h41 && c <= 8'h46) ||
                 (c >= 8'h61 && c <= 8'h66);
  endfunction : iwf_is_hex

  function automatic logic [3:0] iwf_hex_to_nib(input logic [7:0] c);
    logic [7:0] v;
    v = 8'h00;
    if (c <= 8'h39)
      v = c - 8'h30;
    else if (c <= 8'h46)
      v = c - 8'h37;
    else
      v = c - 8'h57;
    iwf_hex_to_nib = v[3:0];
  endfunction : iwf_hex_to_nib

  // Upper-case digits on the way out
  function automatic logic [7:0] iwf_nib_to_hex(input logic [3:0] n);
    iwf_nib_to_hex = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : iwf_nib_to_hex

  // Zero is illegal and anything past eight is meaningless; clamp both
  function automatic logic [3:0] iwf_eff_words(input logic [3:0] w);
    if (w == 4'h0)
      iwf_eff_words = 4'h1;
    else if (w > 4'h8)
      iwf_eff_words = 4'h8;
    else
      iwf_eff_words = w;
  endfunction : iwf_eff_words

endpackage : iwf_pkg

/* File: src/iwf_evt_filter.sv */
`timescale 1ns/1ps
`include "iwf_consts.svh"

module iwf_evt_filter #(
  parameter int F5_CYCLES  = `IWF_FILT5_US * `IWF_CLK_MHZ,
  parameter int F20_CYCLES = `IWF_FILT20_US * `IWF_CLK_MHZ,
  parameter int F50_CYCLES = `IWF_FILT50_US * `IWF_CLK_MHZ
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire iwf_pkg::iwf_filt_t filt,
  input  wire logic              event_in,
  input  wire logic              count_clear,
  output logic [15:0]            count
);
  import iwf_pkg::*;

  iwf_flt_st_t st_reg;
  iwf_flt_st_t st_next;
  logic [23:0] limit;
  logic        rise;

  // Settle time for the selected constant
  always_comb
  begin
    case (filt)
      IWF_FILT_5MS:  limit = 24'(F5_CYCLES - 1);
      IWF_FILT_20MS: limit = 24'(F20_CYCLES - 1);
      IWF_FILT_50MS: limit = 24'(F50_CYCLES - 1);
      default:       limit = 24'h000000;
    endcase
  end

  // Input must hold its new level for the whole constant before it counts
  always_comb
  begin
    st_next = st_reg;
    rise = 1'b0;
    if (filt == IWF_FILT_NONE)
    begin
      st_next.stable = event_in;
      st_next.cnt = 24'h000000;
    end
    else if (event_in == st_reg.stable)
      st_next.cnt = 24'h000000;
    else if (st_reg.cnt >= limit)
    begin
      st_next.stable = event_in;
      st_next.cnt = 24'h000000;
    end
    else
      st_next.cnt = st_reg.cnt + 24'h000001;
    rise = st_next.stable & ~st_reg.stable;
    // A clear in the same cycle as an edge keeps that edge
    if (count_clear)
      st_next.count = {15'h0000, rise};
    else if (rise)
      st_next.count = st_reg.count + 16'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st_reg <= '0;
    else if (ce)
      st_reg <= st_next;
  end

  assign count = st_reg.count;

endmodule : iwf_evt_filter

/* File: src/iwf_hex_tx.sv */
`timescale 1ns/1ps
`include "iwf_consts.svh"

module iwf_hex_tx (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic [63:0] data,
  input  wire logic [3:0]  words,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_char,
  output logic             tx_last,
  output logic             busy
);
  import iwf_pkg::*;

  iwf_tx_state_t st_reg;
  iwf_tx_state_t st_next;
  logic [63:0]   aligned;

  // Left-align the used words so the top digit goes first, LSB digit last
  assign aligned = data << {(`IWF_MAX_WORDS - words), 3'b000};

  always_comb
  begin
    st_next = st_reg;
    case (st_reg.st)
      IWF_TX_IDLE:
      begin
        if (start)
        begin
          st_next.st = IWF_TX_SEND;
          st_next.chr = iwf_nib_to_hex(aligned[63:60]);
          st_next.sh = aligned << 4;
          st_next.left = {words, 1'b0};
          st_next.valid = 1'b1;
          st_next.last = (words == 4'h0);
        end
      end
      IWF_TX_SEND:
      begin
        if (tx_ready)
        begin
          if (st_reg.left == 5'h01)
          begin
            st_next.st = IWF_TX_IDLE;
            st_next.valid = 1'b0;
            st_next.last = 1'b0;
          end
          else
          begin
            st_next.chr = iwf_nib_to_hex(st_reg.sh[63:60]);
            st_next.sh = st_reg.sh << 4;
            st_next.left = st_reg.left - 5'h01;
            st_next.last = (st_reg.left == 5'h02);
          end
        end
      end
      default:
        st_next = '0;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st_reg <= '0;
    else if (ce)
      st_reg <= st_next;
  end

  assign tx_valid = st_reg.valid;
  assign tx_char  = st_reg.chr;
  assign tx_last  = st_reg.last;
  assign busy     = (st_reg.st == IWF_TX_SEND);

endmodule : iwf_hex_tx

/* File: dv/iwf_setup_io_monitor.sv */
`timescale 1ns/1ps

module iwf_setup_io_monitor #(
  parameter int IO_LINES = 15
) (
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic                ce,
  input wire logic                setup_wr_stb,
  input wire logic [31:0]         setup_wr_data,
  input wire logic                write_armed,
  input wire logic                setup_wr_ack,
  input wire logic                setup_wr_refused,
  input wire logic                setup_rd_stb,
  input wire logic                setup_rd_valid,
  input wire logic                syntax_err,
  input wire logic [IO_LINES-1:0] out_lines,
  input wire logic                rd_stb,
  input wire logic                tx_valid,
  input wire logic [7:0]          tx_char,
  input wire logic                tx_last,
  input wire logic                tx_ready,
  input wire logic                tx_busy,
  input wire logic                bit_stb,
  input wire logic [5:0]          bit_idx,
  input wire logic                bit_err,
  input wire logic [3:0]          word_count,
  input wire iwf_pkg::iwf_filt_t  filter_sel
);
  import iwf_pkg::*;

  logic [4:0] nchr;
  logic [3:0] eff;
  logic [5:0] wr_low;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Zero acts as one word, counts past eight as eight
  always_comb
  begin
    eff = (word_count > 4'h8) ? 4'h8 : word_count;
    if (word_count == 4'h0)
      eff = 4'h1;
    wr_low = setup_wr_data[5:0];
  end

  // Characters of the running reply taken by the host so far
  always_ff @(posedge core_clk)
    if (!rst_n)
      nchr <= 5'h0;
    else if (ce && tx_valid && tx_ready)
      nchr <= tx_last ? 5'h0 : nchr + 5'h1;

  a_wr_stored: assert property (
    ce && setup_wr_stb && write_armed |=> setup_wr_ack &&
    {filter_sel, word_count} == $past(wr_low))
    else $error("setup write not stored");
  a_wr_refused: assert property (
    ce && setup_wr_stb && !write_armed |=> setup_wr_refused && !setup_wr_ack)
    else $error("unarmed setup write not refused");
  a_rd_answer: assert property (
    ce && setup_rd_stb |=> setup_rd_valid)
    else $error("setup read not answered");
  a_reply_start: assert property (
    ce && rd_stb && !tx_busy |=> tx_valid)
    else $error("reply did not start");
  a_char_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
    else $error("reply character dropped");
  a_reply_len: assert property (
    tx_valid && tx_last |-> nchr + 5'h1 == {eff, 1'h0})
    else $error("reply length wrong");
  a_hex_case: assert property (
    tx_valid |-> tx_char inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("reply character not hex");
  a_err_keeps: assert property (
    syntax_err |-> $stable(out_lines))
    else $error("rejected command moved outputs");
  a_bit_range: assert property (
    ce && bit_stb && bit_idx >= IO_LINES |=> bit_err)
    else $error("bit index past lines not flagged");
endmodule : iwf_setup_io_monitor

bind iwf_setup_io iwf_setup_io_monitor #(.IO_LINES(IO_LINES)) u_mon (
  .core_clk, .rst_n, .ce, .setup_wr_stb, .setup_wr_data, .write_armed,
  .setup_wr_ack, .setup_wr_refused, .setup_rd_stb, .setup_rd_valid,
  .syntax_err, .out_lines, .rd_stb, .tx_valid, .tx_char, .tx_last,
  .tx_ready, .tx_busy, .bit_stb, .bit_idx, .bit_err, .word_count,
  .filter_sel);

/* File: dv/iwf_host_model.sv */
`timescale 1ns/1ps

module iwf_host_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_char,
  input  wire logic       tx_last,
  output logic            tx_ready,
  output logic [63:0]     rx_val,
  output logic [4:0]      rx_cnt
);
  logic       fresh;
  logic [3:0] nib;

  // Letters sit nine above their low nibble
  always_comb
    nib = tx_char[6] ? tx_char[3:0] + 4'h9 : tx_char[3:0];

  // A slow host takes a character only every other cycle, to stress holding
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      tx_ready <= 1'h0;
      fresh    <= 1'h1;
      rx_val   <= 64'h0;
      rx_cnt   <= 5'h0;
    end
    else
    begin
      tx_ready <= slow ? ~tx_ready : 1'h1;
      if (tx_valid && tx_ready)
      begin
        rx_val <= fresh ? {60'h0, nib} : {rx_val[59:0], nib};
        rx_cnt <= fresh ? 5'h1 : rx_cnt + 5'h1;
        fresh  <= tx_last;
      end
    end
  end
endmodule : iwf_host_model

/* File: dv/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
  import iwf_pkg::*;

  logic        core_clk, rst_n, ce, write_armed, slow;
  logic        setup_wr_stb, setup_wr_ack, setup_wr_refused;
  logic [31:0] setup_wr_data, setup_rd_data;
  logic        setup_rd_stb, setup_rd_valid;
  logic        do_char_valid, do_char_last, do_ack, syntax_err;
  logic [7:0]  do_char, tx_char;
  logic [14:0] out_lines, in_lines;
  logic        rd_stb, tx_valid, tx_last, tx_ready, tx_busy;
  iwf_src_t    rd_src;
  logic        bit_stb, bit_val, bit_err, event_in, event_clear;
  logic [5:0]  bit_idx;
  logic [15:0] event_count;
  logic [3:0]  word_count;
  iwf_filt_t   filter_sel;
  logic [63:0] rx_val;
  logic [4:0]  rx_cnt;
  int          fails, cmp_count;

  iwf_setup_io #(.F5_CYCLES(20), .F20_CYCLES(40), .F50_CYCLES(80)) u_dut (
    .core_clk, .rst_n, .ce, .setup_wr_stb, .setup_wr_data, .write_armed,
    .setup_wr_ack, .setup_wr_refused, .setup_rd_stb, .setup_rd_data,
    .setup_rd_valid, .do_char_valid, .do_char, .do_char_last, .do_ack,
    .syntax_err, .out_lines, .in_lines, .rd_stb, .rd_src, .tx_valid,
    .tx_char, .tx_last, .tx_ready, .tx_busy, .bit_stb, .bit_idx, .bit_val,
    .bit_err, .event_in, .event_clear, .event_count, .word_count,
    .filter_sel);

  iwf_host_model u_host (
    .core_clk, .rst_n, .slow, .tx_valid, .tx_char, .tx_last, .tx_ready,
    .rx_val, .rx_cnt);

  // 200 MHz core clock
  initial
  begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [63:0] exp,
                     input logic [63:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // Answers are sampled just after the edge that takes the request
  task automatic su(input logic arm, input logic [31:0] d);
    @(posedge core_clk);
    write_armed   <= arm;
    setup_wr_stb  <= 1'h1;
    setup_wr_data <= d;
    @(posedge core_clk);
    setup_wr_stb <= 1'h0;
    #1;
    chk("wr_ack", arm, setup_wr_ack);
    chk("wr_refused", !arm, setup_wr_refused);
  endtask : su

  task automatic rs(input logic [31:0] exp);
    @(posedge core_clk);
    setup_rd_stb <= 1'h1;
    @(posedge core_clk);
    setup_rd_stb <= 1'h0;
    #1;
    chk("rd_valid", 1'h1, setup_rd_valid);
    chk("setup", exp, setup_rd_data);
  endtask : rs

  task automatic dout(input string s, input logic ok, input logic [14:0] e);
    for (int i = 0; i < s.len(); i++)
    begin
      @(posedge core_clk);
      do_char_valid <= 1'h1;
      do_char       <= s[i];
      do_char_last  <= (i == s.len() - 1);
    end
    @(posedge core_clk);
    do_char_valid <= 1'h0;
    do_char_last  <= 1'h0;
    #1;
    chk("do_ack", ok, do_ack);
    chk("syntax_err", !ok, syntax_err);
    chk("out_lines", e, out_lines);
  endtask : dout

  // Bounded wait: a reply that never ends stops the wait after 200 cycles and the checks run anyway
  task automatic rd(input iwf_src_t src, input logic [63:0] e,
                    input logic [4:0] n);
    @(posedge core_clk);
    rd_stb <= 1'h1;
    rd_src <= src;
    @(posedge core_clk);
    rd_stb <= 1'h0;
    #1;
    for (int i = 0; i < 200 && tx_busy !== 1'h0; i++)
      @(posedge core_clk) #1;
    chk("reply", e, rx_val);
    chk("reply_len", n, rx_cnt);
  endtask : rd

  task automatic bop(input logic [5:0] idx, input logic v, input logic err,
                     input logic [14:0] e);
    @(posedge core_clk);
    bit_stb <= 1'h1;
    bit_idx <= idx;
    bit_val <= v;
    @(posedge core_clk);
    bit_stb <= 1'h0;
    #1;
    chk("bit_err", err, bit_err);
    chk("out_lines", e, out_lines);
  endtask : bop

  task automatic ev(input int hi, input int lo, input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      event_in <= 1'h1;
      repeat (hi) @(posedge core_clk);
      event_in <= 1'h0;
      repeat (lo - 1) @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
    event_clear <= 1'h0;
    #1;
  endtask : ev

  task automatic clr();
    @(posedge core_clk);
    event_clear <= 1'h1;
    @(posedge core_clk);
    event_clear <= 1'h0;
    #1;
    chk("count", 1'h0, event_count);
  endtask : clr

  task automatic t_setup();
    rs(32'h31070102);
    su(1'h0, 32'h31070105);
    chk("words", 4'h2, word_count);
    su(1'h1, 32'h310701C3);
    chk("words", 4'h3, word_count);
    rs(32'h310701C3);
    for (int f = 0; f < 4; f++)
    begin
      su(1'h1, {24'h310701, 2'h0, f[1:0], 4'h8});
      chk("filter", f[1:0], filter_sel);
      chk("words", 4'h8, word_count);
    end
  endtask : t_setup

  task automatic t_dout();
    su(1'h1, 32'h31070102);
    dout("1234", 1'h1, 15'h1234);
    dout("12345", 1'h0, 15'h1234);
    dout("12G4", 1'h0, 15'h1234);
    su(1'h1, 32'h31070103);
    dout("123456", 1'h1, 15'h3456);
    su(1'h1, 32'h31070101);
    dout("34", 1'h1, 15'h0034);
  endtask : t_dout

  task automatic t_reads();
    @(posedge core_clk);
    slow     <= 1'h1;
    in_lines <= 15'h0ABC;
    su(1'h1, 32'h31070103);
    rd(IWF_SRC_INPUT, 64'hFF8ABC, 5'h6);
    rd(IWF_SRC_OUTPUT, 64'hFF8034, 5'h6);
    rd(IWF_SRC_INIT, 64'hFF8000, 5'h6);
    su(1'h1, 32'h31070108);
    rd(IWF_SRC_INPUT, 64'hFFFFFFFFFFFF8ABC, 5'h10);
    slow <= 1'h0;
    su(1'h1, 32'h31070101);
    rd(IWF_SRC_INPUT, 64'hBC, 5'h2);
  endtask : t_reads

  task automatic t_bits();
    bop(6'h3, 1'h1, 1'h0, 15'h003C);
    bop(6'hE, 1'h1, 1'h0, 15'h403C);
    bop(6'h2, 1'h0, 1'h0, 15'h4038);
    bop(6'hF, 1'h1, 1'h1, 15'h4038);
  endtask : t_bits

  // Short bounces must vanish once the 20-cycle filter is chosen
  task automatic t_event();
    clr();
    ev(2, 2, 3);
    chk("events", 16'h3, event_count);
    su(1'h1, 32'h31070111);
    clr();
    ev(5, 5, 3);
    ev(30, 30, 1);
    chk("events", 16'h1, event_count);
    // The 40-cycle constant must swallow a 30-cycle pulse but pass 45
    su(1'h1, 32'h31070121);
    clr();
    ev(30, 30, 1);
    ev(45, 45, 1);
    chk("events", 16'h1, event_count);
    // The 80-cycle constant must swallow 60 cycles but pass 90
    su(1'h1, 32'h31070131);
    clr();
    ev(60, 60, 1);
    ev(90, 90, 1);
    chk("events", 16'h1, event_count);
  endtask : t_event

  // A low clock enable must hold every register, the setup included
  task automatic t_freeze();
    @(posedge core_clk);
    ce            <= 1'h0;
    write_armed   <= 1'h1;
    setup_wr_stb  <= 1'h1;
    setup_wr_data <= 32'h31070104;
    repeat (2) @(posedge core_clk);
    setup_wr_stb <= 1'h0;
    ce           <= 1'h1;
    #1;
    chk("words", 4'h1, word_count);
    chk("wr_ack", 1'h0, setup_wr_ack);
    repeat (2) @(posedge core_clk);
    #1;
    chk("words", 4'h1, word_count);
  endtask : t_freeze

  // Reset for six cycles, then the scenarios in turn
  initial
  begin
    {rst_n, write_armed, setup_wr_stb, setup_rd_stb, slow} = 5'h0;
    {do_char_valid, do_char_last, rd_stb, bit_stb, bit_val} = 5'h0;
    {event_in, event_clear, bit_idx, do_char} = 16'h0;
    ce            = 1'h1;
    setup_wr_data = 32'h0;
    in_lines      = 15'h0;
    rd_src        = IWF_SRC_INPUT;
    fails         = 0;
    cmp_count     = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'h1;
    t_setup();
    t_dout();
    t_reads();
    t_bits();
    t_event();
    t_freeze();
    print_verdict();
  end

  // Watchdog: the sequence needs far fewer than 10000 cycles
  initial
  begin
    repeat (10000) @(posedge core_clk);
    fails++;
    print_verdict();
  end
endmodule : tb_top
